//--- core/gbr_pkg.sv
package gbr_pkg;

  // register window geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] LOWER_TOP = 6'h1f;

  // common bank locations, visible whatever the bank selection
  localparam logic [ADDR_W-1:0] PART_ID_ADDR = 6'h20;
  localparam logic [ADDR_W-1:0] BANK_SEL_ADDR = 6'h21;
  localparam logic [ADDR_W-1:0] SYS_STATE_ADDR = 6'h22;
  localparam logic [ADDR_W-1:0] RATE_X_HIGH_ADDR = 6'h23;
  localparam logic [ADDR_W-1:0] RATE_X_LOW_ADDR = 6'h24;
  localparam logic [ADDR_W-1:0] RATE_Y_HIGH_ADDR = 6'h25;
  localparam logic [ADDR_W-1:0] RATE_Y_LOW_ADDR = 6'h26;
  localparam logic [ADDR_W-1:0] RATE_Z_HIGH_ADDR = 6'h27;
  localparam logic [ADDR_W-1:0] RATE_Z_LOW_ADDR = 6'h28;
  localparam logic [ADDR_W-1:0] THERMAL_HIGH_ADDR = 6'h29;
  localparam logic [ADDR_W-1:0] THERMAL_LOW_ADDR = 6'h2a;
  localparam logic [ADDR_W-1:0] HP_CLEAR_ADDR = 6'h3b;
  localparam logic [ADDR_W-1:0] QUEUE_COUNT_ADDR = 6'h3c;
  localparam logic [ADDR_W-1:0] QUEUE_FLAGS_ADDR = 6'h3d;
  localparam logic [ADDR_W-1:0] QUEUE_DATA_ADDR = 6'h3e;
  localparam logic [ADDR_W-1:0] PARITY_CLEAR_ADDR = 6'h3f;

  // read-only locations inside the user banks
  localparam logic [ADDR_W-1:0] SYNC_CFG_ADDR = 6'h1a;
  localparam logic [ADDR_W-1:0] SYNC_CNT_ADDR = 6'h1b;
  localparam logic [ADDR_W-1:0] INT_LIVE_ADDR = 6'h0d;
  localparam logic [ADDR_W-1:0] INT_LINE1_ADDR = 6'h0e;
  localparam logic [ADDR_W-1:0] INT_LINE2_ADDR = 6'h0f;
  localparam logic [ADDR_W-1:0] SERIAL_BASE_ADDR = 6'h1a;
  localparam int SERIAL_BYTES = 6;

  // reset values of the common read/write locations
  localparam logic [DATA_W-1:0] BANK_SEL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] HP_CLEAR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam int BANK_BIT = 0;

  // user bank 0 read/write slots: power, sensing, data-ready, io, iface,
  // otp, queue threshold and queue mode
  localparam int B0_N = 10;
  localparam logic [B0_N-1:0][ADDR_W-1:0] B0_ADDR = {
    6'h18, 6'h17, 6'h16, 6'h15, 6'h14,
    6'h13, 6'h03, 6'h02, 6'h01, 6'h00};
  localparam logic [B0_N-1:0][DATA_W-1:0] B0_RESET = {
    8'h00, 8'h00, 8'h00, 8'h04, 8'h00,
    8'h01, 8'h00, 8'h23, 8'h28, 8'h07};
  localparam int B0_SENSE_LP_SLOT = 1;
  localparam int B0_OTP_SLOT = 7;

  // user bank 1 read/write slots: references, debounce, zone masks,
  // and/or mask, int config, timeout, line source masks
  localparam int B1_N = 15;
  localparam logic [B1_N-1:0][ADDR_W-1:0] B1_ADDR = {
    6'h11, 6'h10, 6'h0c, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h07,
    6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
  localparam logic [B1_N-1:0][DATA_W-1:0] B1_RESET = {
    8'h02, 8'h80, 8'h00, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int B1_REF_X_SLOT = 0;

  typedef logic [B0_N-1:0][DATA_W-1:0] gbr_bank0_t;
  typedef logic [B1_N-1:0][DATA_W-1:0] gbr_bank1_t;

  // live measurements from the sensing path
  typedef struct packed {
    logic [15:0] rate_x;
    logic [15:0] rate_y;
    logic [15:0] rate_z;
    logic [15:0] thermal;
  } gbr_meas_t;

  // state owned by the rest of the device, shown read-only
  typedef struct packed {
    logic [7:0] system_state;
    logic [7:0] int_sources_live;
    logic [7:0] int_line1_latched;
    logic [7:0] int_line2_latched;
    logic [7:0] queue_count;
    logic [7:0] queue_flags;
    logic [7:0] queue_data;
    logic [7:0] sync_pin_config;
    logic [7:0] sync_capture_count;
  } gbr_status_t;

endpackage

//--- core/gbr_byte_regs.sv
`timescale 1ns/100ps
`default_nettype none

// a row of byte-wide read/write registers with per-slot write enables
module gbr_byte_regs #(
  parameter int N = 1,
  parameter logic [N-1:0][7:0] RESET_VAL = '0
) (
  input wire logic sys_clk_in,                // system clock
  input wire logic resetn_in,                 // async reset, active low
  input wire logic [N-1:0] wr_en_in,          // one write enable per slot
  input wire logic [7:0] wdata_in,            // byte to store
  output logic [N-1:0][7:0] q_out             // stored bytes
);

  // each slot loads only on its own enable, so a miss changes nothing
  for (genvar i = 0; i < N; i++)
  begin : g_slot
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
      if (!resetn_in)
      begin
        q_out[i] <= RESET_VAL[i];
      end
      else if (wr_en_in[i])
      begin
        q_out[i] <= wdata_in;
      end
    end
  end

endmodule
`default_nettype wire

//--- core/gbr_register_map.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - locations 0x20 to 0x3F stay reachable whatever bank is selected.
// - locations 0x00 to 0x1F show the user bank chosen at 0x21.
// - lower 32 locations are banked so 96 locations fit 64 addresses.
// - each rate axis reads as two bytes, upper byte at lower address.
// - temperature reads as high byte at 0x29 and low byte at 0x2A.
// - location 0x3C reports samples available in the queue, passed through from status_in.queue_count.
// - queue contents are drained by repeated reads of location 0x3E.
// - writing 0x3F clears parity state; the location does not keep data.
// - user bank 0 holds power, sensing, io, iface, queue and sync setup.
// - user bank 1 holds interrupt setup and the serial number bytes.
// - serial number reads as six bytes at bank 1 0x1A to 0x1F.
// - bank 1 holds per-axis references 0x00-0x02 and debounce 0x03-0x05.
// - bank 1 holds zone masks 0x06-0x08 and the and/or mask at 0x09.
// - bank 1 shows live sources 0x0D and latched line status 0x0E, 0x0F.
// - bank 0 location 0x01 is read/write sensing setup, reset 0x28.
// - bank 0 location 0x16 is read/write iface and otp setup, reset zero.
module gbr_register_map #(
  parameter logic [7:0] PART_ID = 8'h5a         // arbitrary identity value
) (
  input wire logic sys_clk_in,                  // system clock, 250 MHz
  input wire logic resetn_in,                   // async reset, active low
  input wire logic [5:0] reg_addr_in,           // register location
  input wire logic reg_wr_in,                   // write strobe
  input wire logic [7:0] reg_wdata_in,          // write byte
  input wire logic reg_rd_in,                   // read strobe
  output logic [7:0] reg_rdata_out,             // read byte, next cycle
  input wire gbr_pkg::gbr_meas_t meas_in,       // live measurements
  input wire gbr_pkg::gbr_status_t status_in,   // device-owned state
  input wire logic [47:0] serial_number_in,     // per-device serial number
  output logic queue_pop_out,                   // advance queue head
  output logic parity_clear_out,                // one-cycle parity clear
  output logic bank_one_out,                    // user bank 1 is mapped
  output logic [7:0] highpass_clear_out,        // stored highpass clear
  output gbr_pkg::gbr_bank0_t bank0_cfg_out,    // bank 0 settings
  output gbr_pkg::gbr_bank1_t bank1_cfg_out     // bank 1 settings
);
  import gbr_pkg::*;

  logic [7:0] bank_selector;
  logic [7:0] next_rdata;
  logic [B0_N-1:0] b0_wr;
  logic [B1_N-1:0] b1_wr;
  logic lower_hit;

  // true for the banked half of the window
  function automatic logic in_lower(input logic [ADDR_W-1:0] a);
    in_lower = (a <= LOWER_TOP);
  endfunction

  // true for a location of the common half at a given address
  function automatic logic common_at(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] loc);
    common_at = !in_lower(a) && (a == loc);
  endfunction

  assign lower_hit = in_lower(reg_addr_in);

  // only bit zero picks the bank; the full byte reads back as written
  assign bank_one_out = bank_selector[BANK_BIT];

  // bank selection register
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bank_selector <= BANK_SEL_RESET;
    end
    else if (reg_wr_in && common_at(reg_addr_in, BANK_SEL_ADDR))
    begin
      bank_selector <= reg_wdata_in;
    end
  end

  // highpass clear keeps its value; the filter logic owns its meaning
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      highpass_clear_out <= HP_CLEAR_RESET;
    end
    else if (reg_wr_in && common_at(reg_addr_in, HP_CLEAR_ADDR))
    begin
      highpass_clear_out <= reg_wdata_in;
    end
  end

  // parity clear is a pulse, nothing is stored, so reads stay zero
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      parity_clear_out <= 1'b0;
    end
    else
    begin
      parity_clear_out <= reg_wr_in &&
        common_at(reg_addr_in, PARITY_CLEAR_ADDR);
    end
  end

  // write decode per bank: a slot only loads while its bank is mapped
  for (genvar i = 0; i < B0_N; i++)
  begin : g_b0_wr
    assign b0_wr[i] = reg_wr_in && lower_hit && !bank_one_out &&
      (reg_addr_in == B0_ADDR[i]);
  end
  for (genvar j = 0; j < B1_N; j++)
  begin : g_b1_wr
    assign b1_wr[j] = reg_wr_in && lower_hit && bank_one_out &&
      (reg_addr_in == B1_ADDR[j]);
  end

  // bank 0: power, sensing, data-ready, io, iface/otp, queue setup
  gbr_byte_regs #(
    .N(B0_N),
    .RESET_VAL(B0_RESET)
  ) u_bank0 (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(b0_wr),
    .wdata_in(reg_wdata_in),
    .q_out(bank0_cfg_out)
  );

  // bank 1: references, debounce, masks, interrupt setup and timeout
  gbr_byte_regs #(
    .N(B1_N),
    .RESET_VAL(B1_RESET)
  ) u_bank1 (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(b1_wr),
    .wdata_in(reg_wdata_in),
    .q_out(bank1_cfg_out)
  );

  // read selection; anything not matched below is reserved and reads zero
  always_comb
  begin
    next_rdata = ZERO_BYTE;
    if (!lower_hit)
    begin
      unique case (reg_addr_in)
        PART_ID_ADDR: next_rdata = PART_ID;
        BANK_SEL_ADDR: next_rdata = bank_selector;
        SYS_STATE_ADDR: next_rdata = status_in.system_state;
        RATE_X_HIGH_ADDR: next_rdata = meas_in.rate_x[15:8];
        RATE_X_LOW_ADDR: next_rdata = meas_in.rate_x[7:0];
        RATE_Y_HIGH_ADDR: next_rdata = meas_in.rate_y[15:8];
        RATE_Y_LOW_ADDR: next_rdata = meas_in.rate_y[7:0];
        RATE_Z_HIGH_ADDR: next_rdata = meas_in.rate_z[15:8];
        RATE_Z_LOW_ADDR: next_rdata = meas_in.rate_z[7:0];
        THERMAL_HIGH_ADDR: next_rdata = meas_in.thermal[15:8];
        THERMAL_LOW_ADDR: next_rdata = meas_in.thermal[7:0];
        HP_CLEAR_ADDR: next_rdata = highpass_clear_out;
        QUEUE_COUNT_ADDR: next_rdata = status_in.queue_count;
        QUEUE_FLAGS_ADDR: next_rdata = status_in.queue_flags;
        QUEUE_DATA_ADDR: next_rdata = status_in.queue_data;
        PARITY_CLEAR_ADDR: next_rdata = ZERO_BYTE;
        default: next_rdata = ZERO_BYTE;
      endcase
    end
    else if (bank_one_out)
    begin
      // the lower half is reused by bank 1, giving 96 locations in 64 addresses
      for (int i = 0; i < B1_N; i++)
      begin
        if (reg_addr_in == B1_ADDR[i])
        begin
          next_rdata = bank1_cfg_out[i];
        end
      end
      if (reg_addr_in == INT_LIVE_ADDR)
      begin
        next_rdata = status_in.int_sources_live;
      end
      if (reg_addr_in == INT_LINE1_ADDR)
      begin
        next_rdata = status_in.int_line1_latched;
      end
      if (reg_addr_in == INT_LINE2_ADDR)
      begin
        next_rdata = status_in.int_line2_latched;
      end
      for (int k = 0; k < SERIAL_BYTES; k++)
      begin
        if (reg_addr_in == SERIAL_BASE_ADDR + 6'(k))
        begin
          next_rdata = serial_number_in[k*8 +: 8];
        end
      end
    end
    else
    begin
      for (int i = 0; i < B0_N; i++)
      begin
        if (reg_addr_in == B0_ADDR[i])
        begin
          next_rdata = bank0_cfg_out[i];
        end
      end
      if (reg_addr_in == SYNC_CFG_ADDR)
      begin
        next_rdata = status_in.sync_pin_config;
      end
      if (reg_addr_in == SYNC_CNT_ADDR)
      begin
        next_rdata = status_in.sync_capture_count;
      end
    end
  end

  // read data is registered; it holds until the next read strobe
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      reg_rdata_out <= ZERO_BYTE;
    end
    else if (reg_rd_in)
    begin
      reg_rdata_out <= next_rdata;
    end
  end

  // each read of the queue port takes the head and advances it, so a
  // burst of reads drains successive entries
  assign queue_pop_out = reg_rd_in &&
    common_at(reg_addr_in, QUEUE_DATA_ADDR);

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_common_id_read: assert property (
    reg_rd_in && reg_addr_in == PART_ID_ADDR |=> reg_rdata_out == PART_ID)
    else $error("identity read wrong");

  a_bank_select_write: assert property (
    reg_wr_in && reg_addr_in == BANK_SEL_ADDR
      |=> bank_selector == $past(reg_wdata_in))
    else $error("bank selection not stored");

  a_bank_one_view: assert property (
    reg_rd_in && bank_one_out && reg_addr_in == B1_ADDR[B1_REF_X_SLOT]
      |=> reg_rdata_out == $past(bank1_cfg_out[B1_REF_X_SLOT]))
    else $error("bank 1 not mapped at lower window");

  a_bank_zero_view: assert property (
    reg_rd_in && !bank_one_out && reg_addr_in == B0_ADDR[B0_SENSE_LP_SLOT]
      |=> reg_rdata_out == $past(bank0_cfg_out[B0_SENSE_LP_SLOT]))
    else $error("bank 0 sensing setup read wrong");

  a_rate_x_high: assert property (
    reg_rd_in && reg_addr_in == RATE_X_HIGH_ADDR
      |=> reg_rdata_out == $past(meas_in.rate_x[15:8]))
    else $error("rate x upper byte wrong");

  a_rate_z_low: assert property (
    reg_rd_in && reg_addr_in == RATE_Z_LOW_ADDR
      |=> reg_rdata_out == $past(meas_in.rate_z[7:0]))
    else $error("rate z lower byte wrong");

  a_thermal_low: assert property (
    reg_rd_in && reg_addr_in == THERMAL_LOW_ADDR
      |=> reg_rdata_out == $past(meas_in.thermal[7:0]))
    else $error("temperature lower byte wrong");

  a_queue_count: assert property (
    reg_rd_in && reg_addr_in == QUEUE_COUNT_ADDR
      |=> reg_rdata_out == $past(status_in.queue_count))
    else $error("queue count read wrong");

  a_queue_flags: assert property (
    reg_rd_in && reg_addr_in == QUEUE_FLAGS_ADDR
      |=> reg_rdata_out == $past(status_in.queue_flags))
    else $error("queue flags read wrong");

  a_queue_drain: assert property (
    reg_rd_in && reg_addr_in == QUEUE_DATA_ADDR
      |-> queue_pop_out ##1 reg_rdata_out == $past(status_in.queue_data))
    else $error("queue read did not pop");

  a_pop_only_on_read: assert property (
    queue_pop_out |-> reg_rd_in && reg_addr_in == QUEUE_DATA_ADDR)
    else $error("queue popped without a read");

  a_parity_pulse: assert property (
    reg_wr_in && reg_addr_in == PARITY_CLEAR_ADDR
      ##1 !(reg_wr_in && reg_addr_in == PARITY_CLEAR_ADDR)
      |-> parity_clear_out ##1 !parity_clear_out)
    else $error("parity clear not a single pulse");

  a_parity_reads_zero: assert property (
    reg_rd_in && reg_addr_in == PARITY_CLEAR_ADDR |=> reg_rdata_out == '0)
    else $error("parity location kept data");

  a_reserved_zero: assert property (
    reg_rd_in && reg_addr_in > THERMAL_LOW_ADDR
      && reg_addr_in < HP_CLEAR_ADDR |=> reg_rdata_out == '0)
    else $error("reserved location not zero");

  a_serial_first: assert property (
    reg_rd_in && bank_one_out && reg_addr_in == SERIAL_BASE_ADDR
      |=> reg_rdata_out == $past(serial_number_in[7:0]))
    else $error("serial byte 0 wrong");

  a_line1_status: assert property (
    reg_rd_in && bank_one_out && reg_addr_in == INT_LINE1_ADDR
      |=> reg_rdata_out == $past(status_in.int_line1_latched))
    else $error("line 1 latched status wrong");

  a_otp_write: assert property (
    reg_wr_in && !bank_one_out && reg_addr_in == B0_ADDR[B0_OTP_SLOT]
      |=> bank0_cfg_out[B0_OTP_SLOT] == $past(reg_wdata_in))
    else $error("otp setup not written");

  a_bank_isolation: assert property (
    reg_wr_in && !bank_one_out && lower_hit
      |=> $stable(bank1_cfg_out))
    else $error("hidden bank changed on write");

  a_bank_zero_hold: assert property (
    reg_wr_in && bank_one_out && lower_hit
      |=> $stable(bank0_cfg_out))
    else $error("bank 0 changed while hidden");

  a_ref_x_write: assert property (
    reg_wr_in && bank_one_out && reg_addr_in == B1_ADDR[B1_REF_X_SLOT]
      |=> bank1_cfg_out[B1_REF_X_SLOT] == $past(reg_wdata_in))
    else $error("x reference not written");

  a_line2_status: assert property (
    reg_rd_in && bank_one_out && reg_addr_in == INT_LINE2_ADDR
      |=> reg_rdata_out == $past(status_in.int_line2_latched))
    else $error("line 2 latched status wrong");

  a_parity_idle: assert property (
    !(reg_wr_in && reg_addr_in == PARITY_CLEAR_ADDR) |=> !parity_clear_out)
    else $error("parity clear without a write");

endmodule
`default_nettype wire

//--- dv/gbr_queue_model.sv
`timescale 1ns/100ps
`default_nettype none

// behavioural queue behind the register map: head byte and fill count
module gbr_queue_model #(
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in,   // system clock
  input wire logic resetn_in,    // async reset, active low
  input wire logic pop_in,       // advance the head
  output logic [7:0] head_out,   // byte at the head
  output logic [7:0] count_out   // entries still held
);
  logic [7:0] idx;

  // pops past empty are ignored, as the real queue must do
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      idx <= 8'h00;
    else if (pop_in && idx < 8'(DEPTH))
      idx <= idx + 8'h01;
  end

  // once drained the head shows inverted junk, never a stale entry
  assign head_out = (idx < 8'(DEPTH)) ? 8'hc0 + idx : ~(8'hc0 + idx);
  assign count_out = 8'(DEPTH) - idx;
endmodule

`default_nettype wire

//--- dv/test_gbr_register_map.sv
`timescale 1ns/100ps
`default_nettype none

module test_gbr_register_map;
  import gbr_pkg::*;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [5:0] reg_addr_in = 6'h00;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  gbr_meas_t meas = {16'h8a17, 16'h4c02, 16'hf3e9, 16'h0d61};
  gbr_status_t status;
  logic [47:0] serial = 48'h3625_1403_f2e1;
  logic queue_pop_out;
  logic parity_clear_out;
  logic bank_one_out;
  logic [7:0] highpass_clear_out;
  logic [7:0] q_head;
  logic [7:0] q_count;
  gbr_bank0_t bank0_cfg_out;
  gbr_bank1_t bank1_cfg_out;
  int err_count = 0;
  int num_checks = 0;
  // identity byte given to the instance; the value is arbitrary
  localparam logic [7:0] ID_BYTE = 8'h3c;

  // 2 ns half period gives the 250 MHz system clock
  always #2 sys_clk_in = ~sys_clk_in;

  // device-owned state around the queue model's bytes
  always_comb
    status = {8'h11, 8'h5d, 8'h6e, 8'h7f, q_count, 8'h93, q_head,
              8'ha4, 8'hb5};

  gbr_register_map #(
    .PART_ID(ID_BYTE)
  ) u_dut (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .meas_in(meas),
    .status_in(status),
    .serial_number_in(serial),
    .queue_pop_out(queue_pop_out),
    .parity_clear_out(parity_clear_out),
    .bank_one_out(bank_one_out),
    .highpass_clear_out(highpass_clear_out),
    .bank0_cfg_out(bank0_cfg_out),
    .bank1_cfg_out(bank1_cfg_out)
  );

  gbr_queue_model u_queue (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pop_in(queue_pop_out),
    .head_out(q_head),
    .count_out(q_count)
  );

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] e);
    num_checks++;
    if (seen !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask

  // one-cycle write strobe, launched and dropped on rising edges
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // read data lands on the edge after the strobe; sample once settled
  task automatic expect_rd(input logic [5:0] a, input logic [7:0] e,
                           input string nm);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(nm, reg_rdata_out, e);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // bank 0 and status bytes straight out of reset
  task automatic t_reset_bank0;
    for (int i = 0; i < B0_N; i++)
      expect_rd(B0_ADDR[i], B0_RESET[i], "bank0 reset");
    expect_rd(BANK_SEL_ADDR, 8'h00, "bank select");
    expect_rd(QUEUE_FLAGS_ADDR, 8'h93, "queue flags");
    expect_rd(QUEUE_COUNT_ADDR, 8'h04, "queue count");
  endtask

  // a byte written in one bank must not leak into the other
  task automatic t_banking;
    wr(6'h01, 8'h5c);
    wr(BANK_SEL_ADDR, 8'h01);
    #1;
    chk("bank one", {7'h00, bank_one_out}, 8'h01);
    for (int i = 0; i < B1_N; i++)
      expect_rd(B1_ADDR[i], B1_RESET[i], "bank1 reset");
    wr(6'h01, 8'h3a);
    expect_rd(6'h01, 8'h3a, "bank1 slot 1");
    chk("ref y out", bank1_cfg_out[1], 8'h3a);
    wr(6'h00, 8'h4e);
    expect_rd(6'h00, 8'h4e, "ref x");
    wr(6'h09, 8'h71);
    expect_rd(6'h09, 8'h71, "and or mask");
    expect_rd(INT_LIVE_ADDR, 8'h5d, "int live");
    expect_rd(INT_LINE1_ADDR, 8'h6e, "int line1");
    expect_rd(INT_LINE2_ADDR, 8'h7f, "int line2");
    for (int k = 0; k < SERIAL_BYTES; k++)
      expect_rd(SERIAL_BASE_ADDR + 6'(k), serial[8*k +: 8], "serial");
    wr(INT_LIVE_ADDR, 8'hff);
    expect_rd(INT_LIVE_ADDR, 8'h5d, "int live ro");
    wr(6'h12, 8'hff);
    expect_rd(6'h12, 8'h00, "bank1 reserved");
    expect_rd(RATE_X_HIGH_ADDR, meas.rate_x[15:8], "common in 1");
    expect_rd(PART_ID_ADDR, ID_BYTE, "part id");
    expect_rd(SYS_STATE_ADDR, 8'h11, "system state");
    wr(HP_CLEAR_ADDR, 8'h6b);
    expect_rd(HP_CLEAR_ADDR, 8'h6b, "hp clear");
    chk("hp out", highpass_clear_out, 8'h6b);
    wr(BANK_SEL_ADDR, 8'h00);
    expect_rd(6'h01, 8'h5c, "bank0 slot 1");
    chk("lp cfg", bank0_cfg_out[B0_SENSE_LP_SLOT], 8'h5c);
    wr(6'h16, 8'h9e);
    expect_rd(6'h16, 8'h9e, "otp cfg");
  endtask

  // measurement bytes, high byte first, in both banks; read-only stays
  task automatic t_meas;
    logic [63:0] m;
    m = meas;
    for (int b = 1; b >= 0; b--)
    begin
      wr(BANK_SEL_ADDR, 8'(b));
      for (int i = 0; i < 8; i++)
        expect_rd(RATE_X_HIGH_ADDR + 6'(i), m[63-8*i -: 8], "meas");
    end
    wr(THERMAL_HIGH_ADDR, 8'h00);
    expect_rd(THERMAL_HIGH_ADDR, 8'h0d, "thermal ro");
    wr(6'h2b, 8'hff);
    expect_rd(6'h2b, 8'h00, "common reserved");
    wr(6'h04, 8'hff);
    expect_rd(6'h04, 8'h00, "bank0 reserved");
    wr(SYNC_CFG_ADDR, 8'hff);
    expect_rd(SYNC_CFG_ADDR, 8'ha4, "sync cfg ro");
  endtask

  // parity clear pulses for one cycle and never reads back
  task automatic t_parity;
    wr(PARITY_CLEAR_ADDR, 8'h5a);
    #1;
    chk("parity pulse", {7'h00, parity_clear_out}, 8'h01);
    @(posedge sys_clk_in);
    #1;
    chk("parity end", {7'h00, parity_clear_out}, 8'h00);
    expect_rd(PARITY_CLEAR_ADDR, 8'h00, "parity read");
  endtask

  // back-to-back reads of the data port drain successive entries
  task automatic t_queue;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= QUEUE_DATA_ADDR;
    for (int i = 0; i < 3; i++)
    begin
      #1;
      chk("pop", {7'h00, queue_pop_out}, 8'h01);
      @(posedge sys_clk_in);
      // the last read of the burst drops its strobe on this edge
      if (i == 2)
        reg_rd_in <= 1'b0;
      #1;
      chk("queue byte", reg_rdata_out, 8'hc0 + 8'(i));
    end
    chk("pop idle", {7'h00, queue_pop_out}, 8'h00);
    expect_rd(QUEUE_COUNT_ADDR, 8'h01, "count after");
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    t_reset_bank0;
    t_banking;
    t_meas;
    t_parity;
    t_queue;
    wrap_up;
  end

  // about 90 accesses of two cycles each fit well inside this span
  initial
  begin
    #20000;
    err_count++;
    $display("BAD watchdog expected done seen hang");
    wrap_up;
  end
endmodule

`default_nettype wire
